// file: rx_filter_pkg.sv
/*
 Constants for the receive address filter and receive status block.
 Assumes an 8-bit register port and a byte-wide NRZ receive stream.
*/
// What this block does
// - Save errored frames only when bit 0 set
// - Runts accepted if set, but at least 8
// - All-ones destination needs accept broadcast bit
// - Group destinations must pass hash filter
// - Unicast needs station match unless promiscuous
// - Broadcast uses its own enable only, group enable not OR'd in
// - Status byte stored for good or saved frames that are not missed
// - Status cleared when next frame arrives
// - Intact bit only when no error bits
// - CRC bit and tally on CRC, alignment
// - Off-boundary end with bad CRC: alignment
// - Alignment/CRC pair never reads 10
// - FIFO overflow sets flag, aborts frame
// - No buffer or listen-only: missed flag, tally
// - Status bit 5 gives group match type
// - Receiver off flag follows listen-only mode
// - Deferring flag follows carrier, collision
// - Config write, status read share one offset
// - Every register is eight bits wide
// - Six CRC bits index sixty-four hash bits, only the low thirty-two writable
// - Destination compared bytewise, lowest register first
package rx_filter_pkg;
	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 5;
	// Register offsets
	localparam logic [4:0]  OFF_RX_CONFIG   = 5'h0C;
	localparam logic [4:0]  OFF_STATION0    = 5'h00;
	localparam logic [4:0]  OFF_HASH0       = 5'h08;
	localparam logic [4:0]  OFF_ALIGN_TALLY = 5'h0D;
	localparam logic [4:0]  OFF_CRC_TALLY   = 5'h0E;
	localparam logic [4:0]  OFF_MISS_TALLY  = 5'h0F;
	localparam logic [4:0]  OFF_HASH_END    = 5'h0F;
	// Configuration bits
	localparam int          CFG_SAVE_ERR    = 0;
	localparam int          CFG_SHORT       = 1;
	localparam int          CFG_ALL_ONES    = 2;
	localparam int          CFG_GROUP       = 3;
	localparam int          CFG_ANY_UNI     = 4;
	localparam int          CFG_LISTEN      = 5;
	localparam logic [7:0]  CFG_RESET       = 8'h00;
	localparam logic [7:0]  CFG_MASK        = 8'h3F;
	// Status bits
	localparam int          ST_INTACT       = 0;
	localparam int          ST_CRC          = 1;
	localparam int          ST_ALIGN        = 2;
	localparam int          ST_FIFO         = 3;
	localparam int          ST_MISSED       = 4;
	localparam int          ST_GROUP        = 5;
	localparam int          ST_OFF          = 6;
	localparam int          ST_DEFER        = 7;
	// Length limits in bytes, then CRC constants
	localparam logic [10:0] MIN_FRAME       = 11'd64;
	localparam logic [10:0] MIN_RUNT        = 11'd8;
	localparam logic [10:0] LEN_MAX         = 11'h7FF;
	localparam logic [2:0]  ADDR_BYTES      = 3'd6;
	localparam logic [31:0] CRC_POLY        = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_RESIDUE     = 32'hC704DD7B;
endpackage

// file: rx_filter_status.sv
/*
 Receive address filter and receive status logic.
 Assumes bytes arrive LSB first as pulses from the line codec deserialiser,
 framed by rx_start and rx_end pulses; all inputs synchronous to sys_clk.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module rx_filter_status (
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	input  wire logic [rx_filter_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [rx_filter_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [rx_filter_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                           rx_start,
	input  wire logic                           rx_byte_valid,
	input  wire logic [7:0]                     rx_byte,
	input  wire logic                           rx_end,
	input  wire logic                           rx_dribble,
	input  wire logic                           fifo_overflow,
	input  wire logic                           no_buffer,
	input  wire logic                           carrier_sense,
	input  wire logic                           collision_line,
	output logic                                frame_accept,
	output logic                                frame_reject,
	output logic                                status_store,
	output logic [7:0]                          status_byte
);
	import rx_filter_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Bit-serial CRC step over one byte, LSB first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[31] ^ d[i]) begin
				r = {r[30:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[30:0], 1'b0};
			end
		end
		return r;
	endfunction

	// Saturating tally increment
	function automatic logic [7:0] tally_inc(input logic [7:0] t, input logic en);
		return (en && t != 8'hFF) ? t + 8'h01 : t;
	endfunction

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_DEST = 2'b01,
		S_BODY = 2'b10
	} rx_state_e;

	typedef struct packed {
		rx_state_e      state;
		logic [7:0]     rx_config_reg;
		logic [47:0]    station_address_bytes;
		logic [63:0]    hash_filter_bits;
		logic [7:0]     rx_status_reg;
		logic [7:0]     alignment_tally;
		logic [7:0]     crc_tally;
		logic [7:0]     missed_tally;
		logic [31:0]    crc;
		logic [10:0]    len;
		logic [2:0]     dest_idx;
		logic           uni_match;
		logic           all_ones;
		logic           group;
		logic [5:0]     hash_idx;
		logic           overflow;
		logic [7:0]     rdata;
		logic           accept;
		logic           reject;
		logic           store;
		logic [7:0]     status_out;
	} state_s;

	state_s cur;
	state_s nxt;

	////////////////////////////////////////////////////////////////////////
	// All next-state logic
	always_comb begin
		logic       crc_bad;
		logic       align_err;
		logic       err;
		logic       len_ok;
		logic       addr_ok;
		logic       missed;
		logic       ok;
		logic [7:0] st;
		nxt = cur;
		crc_bad = 1'b0;
		align_err = 1'b0;
		err = 1'b0;
		len_ok = 1'b0;
		addr_ok = 1'b0;
		missed = 1'b0;
		ok = 1'b0;
		st = 8'h00;
		nxt.accept = 1'b0;
		nxt.reject = 1'b0;
		nxt.store = 1'b0;
		nxt.rdata = 8'h00;

		// Register writes; config and status share one offset by direction
		if (reg_wr) begin
			if (reg_addr == OFF_RX_CONFIG) begin
				nxt.rx_config_reg = reg_wdata & CFG_MASK;
			end else if (reg_addr < OFF_STATION0 + 5'(ADDR_BYTES)) begin
				nxt.station_address_bytes[reg_addr[2:0]*8 +: 8] = reg_wdata;
			end else if (reg_addr >= OFF_HASH0 && reg_addr < OFF_RX_CONFIG) begin
				nxt.hash_filter_bits[(reg_addr - OFF_HASH0)*8 +: 8] = reg_wdata;
			end
		end
		// Reads: data in the following cycle only
		if (reg_rd) begin
			if (reg_addr == OFF_RX_CONFIG) begin
				nxt.rdata = cur.rx_status_reg;
			end else if (reg_addr < OFF_STATION0 + 5'(ADDR_BYTES)) begin
				nxt.rdata = cur.station_address_bytes[reg_addr[2:0]*8 +: 8];
			end else if (reg_addr >= OFF_HASH0 && reg_addr < OFF_RX_CONFIG) begin
				nxt.rdata = cur.hash_filter_bits[(reg_addr - OFF_HASH0)*8 +: 8];
			end else if (reg_addr == OFF_ALIGN_TALLY) begin
				nxt.rdata = cur.alignment_tally;
			end else if (reg_addr == OFF_CRC_TALLY) begin
				nxt.rdata = cur.crc_tally;
			end else if (reg_addr == OFF_MISS_TALLY) begin
				nxt.rdata = cur.missed_tally;
			end
		end

		// Live flags follow their sources continuously
		nxt.rx_status_reg[ST_OFF] = nxt.rx_config_reg[CFG_LISTEN];
		nxt.rx_status_reg[ST_DEFER] = carrier_sense | collision_line;

		// Frame sequencer
		if (cur.overflow == 1'b0 && fifo_overflow && cur.state != S_IDLE) begin
			nxt.overflow = 1'b1;
		end
		case (cur.state)
			S_IDLE: begin
				if (rx_start) begin
					// Old frame status dropped on the new arrival
					nxt.rx_status_reg[5:0] = 6'h00;
					nxt.crc = CRC_INIT;
					nxt.len = 11'd0;
					nxt.dest_idx = 3'd0;
					nxt.uni_match = 1'b1;
					nxt.all_ones = 1'b1;
					nxt.group = 1'b0;
					nxt.overflow = 1'b0;
					nxt.state = S_DEST;
				end
			end
			S_DEST, S_BODY: begin
				if (rx_byte_valid) begin
					nxt.crc = crc_byte(cur.crc, rx_byte);
					if (cur.len != LEN_MAX) begin
						nxt.len = cur.len + 11'd1;
					end
				end
				if (cur.state == S_DEST && rx_byte_valid) begin
					// Byte compare, first byte against lowest station byte
					if (rx_byte != cur.station_address_bytes[cur.dest_idx*8 +: 8]) begin
						nxt.uni_match = 1'b0;
					end
					if (rx_byte != 8'hFF) begin
						nxt.all_ones = 1'b0;
					end
					if (cur.dest_idx == 3'd0) begin
						nxt.group = rx_byte[0];
					end
					nxt.dest_idx = cur.dest_idx + 3'd1;
					if (cur.dest_idx == ADDR_BYTES - 3'd1) begin
						// Top six CRC bits after last address bit pick a hash bit
						nxt.hash_idx = nxt.crc[31:26];
						nxt.state = S_BODY;
					end
				end
				if (rx_end || (fifo_overflow && !cur.overflow)) begin
					// Overflow aborts the frame at once
					crc_bad = (nxt.crc != CRC_RESIDUE);
					align_err = rx_dribble && crc_bad && !fifo_overflow;
					st[ST_CRC] = crc_bad && !fifo_overflow;
					st[ST_ALIGN] = align_err;
					st[ST_FIFO] = fifo_overflow || cur.overflow;
					err = st[ST_CRC] | st[ST_ALIGN];
					len_ok = (nxt.len >= MIN_FRAME) ||
						(cur.rx_config_reg[CFG_SHORT] && nxt.len >= MIN_RUNT);
					if (cur.state == S_BODY) begin
						if (cur.all_ones) begin
							addr_ok = cur.rx_config_reg[CFG_ALL_ONES];
						end else if (cur.group) begin
							addr_ok = cur.rx_config_reg[CFG_GROUP] && cur.hash_filter_bits[cur.hash_idx];
						end else begin
							addr_ok = cur.rx_config_reg[CFG_ANY_UNI] || cur.uni_match;
						end
					end
					ok = addr_ok && len_ok && !st[ST_FIFO] &&
						(!err || cur.rx_config_reg[CFG_SAVE_ERR]);
					missed = addr_ok && len_ok && !st[ST_FIFO] &&
						(cur.rx_config_reg[CFG_LISTEN] || no_buffer);
					st[ST_MISSED] = missed;
					st[ST_GROUP] = cur.group | cur.all_ones;
					st[ST_INTACT] = !(st[ST_CRC] | st[ST_ALIGN] | st[ST_FIFO] | missed);
					nxt.rx_status_reg[5:0] = st[5:0];
					nxt.crc_tally = tally_inc(cur.crc_tally, st[ST_CRC]);
					nxt.alignment_tally = tally_inc(cur.alignment_tally, align_err);
					nxt.missed_tally = tally_inc(cur.missed_tally, missed);
					nxt.accept = ok && !missed;
					nxt.reject = !(ok && !missed);
					nxt.store = ok && !missed;
					nxt.status_out = {nxt.rx_status_reg[7:6], st[5:0]};
					nxt.state = S_IDLE;
				end
			end
			default: begin
				nxt.state = S_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur <= '0;
			cur.rx_config_reg <= CFG_RESET;
			cur.state <= S_IDLE;
		end else begin
			cur <= nxt;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = cur.rdata;
	assign frame_accept = cur.accept;
	assign frame_reject = cur.reject;
	assign status_store = cur.store;
	assign status_byte = cur.status_out;
endmodule

// file: rx_filter_status_chk.sv
/*
 Port-level checker for the receive filter and status block.
 Assumes one clock domain and binding onto rx_filter_status.
*/
`timescale 1ns/1ps
module rx_filter_status_chk (
	input wire logic                               sys_clk,
	input wire logic                               rstn,
	input wire logic [rx_filter_pkg::ADDR_W-1:0]   reg_addr,
	input wire logic                               reg_rd,
	input wire logic [rx_filter_pkg::DATA_W-1:0]   reg_rdata,
	input wire logic                               rx_start,
	input wire logic                               rx_end,
	input wire logic                               fifo_overflow,
	input wire logic                               carrier_sense,
	input wire logic                               collision_line,
	input wire logic                               frame_accept,
	input wire logic                               frame_reject,
	input wire logic                               status_store,
	input wire logic [7:0]                         status_byte
);
	import rx_filter_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	// Two cycles of busy line lets the one-cycle flag delay settle
	sequence s_line_busy; (carrier_sense || collision_line) [*2]; endsequence
	sequence s_status_read; reg_rd && reg_addr == OFF_RX_CONFIG; endsequence
	AST_DEFER_SET: assert property (s_line_busy ##0 s_status_read |=> reg_rdata[ST_DEFER])
		else $error("deferring flag missing while line busy");
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_PULSE_EXCL: assert property (!(frame_accept && frame_reject))
		else $error("accept and reject together");
	AST_END_VERDICT: assert property (rx_end |=> frame_accept || frame_reject)
		else $error("no verdict after frame end");
	AST_VERDICT_CAUSE: assert property ((frame_accept || frame_reject) |-> $past(rx_end) || $past(fifo_overflow))
		else $error("verdict without frame end or overflow");
	AST_STORE_ACCEPT: assert property (status_store == frame_accept)
		else $error("status store differs from accept");
	AST_PAIR_LEGAL: assert property (!(status_byte[ST_ALIGN] && !status_byte[ST_CRC]))
		else $error("alignment flag without crc flag");
	AST_INTACT_CLEAN: assert property (status_byte[ST_INTACT] |-> status_byte[ST_MISSED:ST_CRC] == 4'h0)
		else $error("intact flag with error flags");
	AST_STATUS_HOLD: assert property (!$stable(status_byte) |-> $past(rx_end) || $past(rx_start) || $past(fifo_overflow))
		else $error("status changed outside frame boundary");
endmodule
bind rx_filter_status rx_filter_status_chk u_rx_filter_status_chk (.sys_clk, .rstn, .reg_addr, .reg_rd, .reg_rdata,
	.rx_start, .rx_end, .fifo_overflow, .carrier_sense, .collision_line, .frame_accept, .frame_reject, .status_store,
	.status_byte);

// file: rx_stream_model.sv
/*
 Model of the line codec deserialiser feeding bytes to the receive filter.
 Assumes callers enter send right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module rx_stream_model (
	input  wire logic  sys_clk,
	output logic       rx_start,
	output logic       rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic       rx_end,
	output logic       rx_dribble,
	output logic       fifo_overflow
);
	import rx_filter_pkg::*;
	initial {rx_start, rx_byte_valid, rx_byte, rx_end, rx_dribble, fifo_overflow} = '0;
	////////////////////////////////////////////////////////////////
	// Frame check sequence, bit 0 of each byte enters first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		for (int k = 0; k < 8; k++) begin
			c = (c << 1) ^ ((c[31] ^ b[k]) ? CRC_POLY : 32'h0);
		end
		return c;
	endfunction
	// Last four bytes carry the check sequence, so short frames overwrite address bytes
	task automatic send(input logic [47:0] d, input int len, input logic bad, drib, ovf, input int gap);
		logic [31:0] c;
		logic [7:0]  b;
		logic [7:0]  t;
		c = CRC_INIT;
		rx_start <= 1'b1;
		@(posedge sys_clk);
		rx_start <= 1'b0;
		for (int i = 0; i < len; i++) begin
			if (ovf && i == 20) begin
				rx_byte_valid <= 1'b0;
				fifo_overflow <= 1'b1;
				@(posedge sys_clk);
				fifo_overflow <= 1'b0;
				return;
			end
			if (i < len - 4) begin
				b = (i < 6) ? d[8*i +: 8] : 8'(i);
				c = crc_byte(c, b);
			end else begin
				t = ~c[31 - 8*(i - len + 4) -: 8];
				b = {<<{t}};
			end
			if (bad && i == len - 1) b = b ^ 8'h01;
			rx_byte_valid <= 1'b1;
			rx_byte       <= b;
			@(posedge sys_clk);
			// Slow stream: the byte line shows garbage while idle
			if (gap > 0 && i < len - 1) begin
				rx_byte_valid <= 1'b0;
				rx_byte       <= ~b;
				repeat (gap) @(posedge sys_clk);
			end
		end
		rx_byte_valid <= 1'b0;
		rx_byte       <= ~b;
		rx_end        <= 1'b1;
		rx_dribble    <= drib;
		@(posedge sys_clk);
		rx_end     <= 1'b0;
		rx_dribble <= ~drib;
	endtask
endmodule

// file: rx_filter_status_tb_top.sv
/*
 Self-checking bench for the receive filter: table of frames, then edge cases.
 Assumes the stream model and checker files compile before this one.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module rx_filter_status_tb_top;
	import rx_filter_pkg::*;
	typedef struct packed {logic [7:0] cfg; logic [2:0] sel; logic [10:0] len; logic bad, drib, acc; logic [7:0] st;} row_s;
	localparam logic [47:0] STN = 48'h665544332202;
	logic sys_clk, rstn, reg_wr, reg_rd, no_buffer, carrier_sense, collision_line;
	logic rx_start, rx_byte_valid, rx_end, rx_dribble, fifo_overflow, frame_accept, frame_reject, status_store;
	logic [ADDR_W-1:0] reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, rx_byte, status_byte;
	logic [47:0]       m1, m2;
	logic [5:0]        h1;
	int                bad_count, checks, cyc;
	// Configurations keep bit 5 clear
	row_s rows [16] = '{'{8'h00,0,64,0,0,1,8'h01}, '{8'h00,1,64,0,0,0,8'h00}, '{8'h10,1,64,0,0,1,8'h01},
		'{8'h00,2,64,0,0,0,8'h00}, '{8'h04,2,64,0,0,1,8'h21}, '{8'h00,3,64,0,0,0,8'h00}, '{8'h08,3,64,0,0,1,8'h21},
		'{8'h08,4,64,0,0,0,8'h00}, '{8'h0C,3,64,0,0,1,8'h21}, '{8'h0C,0,64,0,0,1,8'h01}, '{8'h00,0,63,0,0,0,8'h00},
		'{8'h12,1,8,0,0,1,8'h01}, '{8'h00,0,64,1,0,0,8'h00}, '{8'h01,0,64,1,0,1,8'h02}, '{8'h01,0,64,1,1,1,8'h06},
		'{8'h01,0,64,0,1,1,8'h01}};
	rx_filter_status u_rx_filter_status (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_start,
		.rx_byte_valid, .rx_byte, .rx_end, .rx_dribble, .fifo_overflow, .no_buffer, .carrier_sense, .collision_line,
		.frame_accept, .frame_reject, .status_store, .status_byte);
	rx_stream_model u_rx_stream_model (.sys_clk, .rx_start, .rx_byte_valid, .rx_byte, .rx_end, .rx_dribble, .fifo_overflow);
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Hang guard: generous ceiling over roughly 2000 cycles of traffic
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Strobes are followed by an idle cycle so no signal is driven twice in one step
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		`CHK(reg_rdata, e)
		@(posedge sys_clk);
	endtask
	function automatic logic [5:0] hash_of(input logic [47:0] d);
		logic [31:0] c;
		c = CRC_INIT;
		for (int k = 0; k < 6; k++) c = u_rx_stream_model.crc_byte(c, d[8*k +: 8]);
		return c[31:26];
	endfunction
	function automatic logic [47:0] pick(input logic [2:0] s);
		case (s)
			3'd0: return STN;
			3'd1: return 48'h775544332202;
			3'd2: return 48'hFFFFFFFFFFFF;
			3'd3: return m1;
			default: return m2;
		endcase
	endfunction
	// Verdict lands one cycle after the end edge, so look at the falling edge
	task automatic frame_case(input logic [7:0] cfg, input logic [2:0] sel, input int len, input logic bad, drib, ovf, acc,
		input logic [7:0] st, input int gap);
		wr(OFF_RX_CONFIG, cfg);
		u_rx_stream_model.send(pick(sel), len, bad, drib, ovf, gap);
		@(negedge sys_clk);
		`CHK(frame_accept, acc)
		if (st != 8'h00) `CHK(status_byte, st)
		@(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{reg_wr, reg_rd, no_buffer, carrier_sense, collision_line, rstn} = '0;
		reg_addr = '0;
		reg_wdata = '0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		`CHK(status_byte, 8'h00)
		rdchk(OFF_RX_CONFIG, 8'h00);
		rdchk(OFF_MISS_TALLY, 8'h00);
		wr(5'h10, 8'h5A);
		rdchk(5'h10, 8'h00);
		for (int k = 0; k < 6; k++) wr(OFF_STATION0 + 5'(k), STN[8*k +: 8]);
		rdchk(OFF_STATION0 + 5'h5, 8'h66);
		// Pick a group address whose hash lands in the reachable filter bytes, then one with another hash
		for (int k = 0; k < 256; k++) begin
			m1 = {32'h0, 8'(k), 8'h01};
			if (hash_of(m1) < 6'd32) break;
		end
		for (int k = 0; k < 256; k++) begin
			m2 = {32'h0, 8'(k), 8'h03};
			if (hash_of(m2) != hash_of(m1)) break;
		end
		h1 = hash_of(m1);
		wr(OFF_HASH0 + 5'(h1 >> 3), 8'h01 << h1[2:0]);
		wr(OFF_RX_CONFIG, 8'h14);
		rdchk(OFF_RX_CONFIG, 8'h00);
		for (int r = 0; r < 16; r++) begin
			frame_case(rows[r].cfg, rows[r].sel, rows[r].len, rows[r].bad, rows[r].drib, 1'b0, rows[r].acc, rows[r].st, r % 2);
		end
		rdchk(OFF_ALIGN_TALLY, 8'h01);
		rdchk(OFF_CRC_TALLY, 8'h03);
		// Full promiscuity: all three address enables set and every reachable hash bit filled with ones
		for (int k = 0; k < 4; k++) wr(OFF_HASH0 + 5'(k), 8'hFF);
		frame_case(8'h1C, 3'd1, 64, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 0);
		frame_case(8'h1C, 3'd3, 64, 1'b0, 1'b0, 1'b0, 1'b1, 8'h21, 1);
		frame_case(8'h12, 3'd1, 7, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 0);
		frame_case(8'h00, 3'd0, 64, 1'b0, 1'b0, 1'b1, 1'b0, 8'h08, 0);
		no_buffer <= 1'b1;
		frame_case(8'h00, 3'd0, 64, 1'b0, 1'b0, 1'b0, 1'b0, 8'h10, 1);
		no_buffer <= 1'b0;
		frame_case(8'h20, 3'd0, 64, 1'b0, 1'b0, 1'b0, 1'b0, 8'h50, 0);
		rdchk(OFF_MISS_TALLY, 8'h02);
		wr(OFF_RX_CONFIG, 8'h00);
		rdchk(OFF_RX_CONFIG, 8'h10);
		carrier_sense <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rdchk(OFF_RX_CONFIG, 8'h90);
		carrier_sense <= 1'b0;
		collision_line <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rdchk(OFF_RX_CONFIG, 8'h90);
		collision_line <= 1'b0;
		give_verdict;
	end
endmodule
